// *** core/trp_user.sv ***
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "trp_defs.svh"
module trp_user (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  trp_if.user port_if
);
  trp_pkg::trp_usr_state_t st_reg, st_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [`TRP_DATA_W-1:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic aw_reg, aw_next, w_reg, w_next;
  logic [31:0] awaddr_reg, awaddr_next, wd_reg, wd_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdat_reg, rdat_next;
  logic go;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    aw_next = aw_reg;
    w_next = w_reg;
    awaddr_next = awaddr_reg;
    wd_next = wd_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdat_next = rdat_reg;
    ctrl_next = ctrl_reg;
    wdata_next = wdata_reg;
    go = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (aw_reg && w_reg && !bvalid_reg)
    begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `TRP_RESP_OKAY;
      unique case ({24'h000000, awaddr_reg[7:0]})
        `TRP_REG_CTRL:
        begin
          ctrl_next = wd_reg;
          go = wd_reg[`TRP_CTRL_GO_BIT] && (st_reg == trp_pkg::TRP_USR_IDLE);
        end
        `TRP_REG_WDATA: wdata_next = wd_reg;
        `TRP_REG_STATUS, `TRP_REG_RDATA: ;
        default: bresp_next = `TRP_RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = `TRP_RESP_OKAY;
      rdat_next = '0;
      unique case ({24'h000000, s_axi_araddr[7:0]})
        `TRP_REG_CTRL: rdat_next = ctrl_reg;
        `TRP_REG_WDATA: rdat_next = wdata_reg;
        `TRP_REG_STATUS:
        begin
          rdat_next[`TRP_STAT_BUSY_BIT] = (st_reg != trp_pkg::TRP_USR_IDLE) || port_if.reconfig_busy;
          rdat_next[`TRP_STAT_DONE_BIT] = done_reg;
          rdat_next[`TRP_STAT_RXPMA_BIT] = port_if.rx_medium_attach_reset_done;
          rdat_next[`TRP_STAT_TXBUF_LSB +: `TRP_TXBUF_W] = port_if.tx_buffer_condition;
        end
        `TRP_REG_RDATA: rdat_next = {16'h0000, rdata_reg};
        default: rresp_next = `TRP_RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  assign s_axi_awready = !aw_reg && !bvalid_reg;
  assign s_axi_wready = !w_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdat_reg;

  ////////////////////////////////////////////////////////////////////////
  // access sequencer: busy gates the launch so no access is posted early
  always_comb
  begin
    st_next = st_reg;
    rdata_next = rdata_reg;
    done_next = done_reg;
    if (go)
    begin
      done_next = 1'b0;
    end
    unique case (st_reg)
      trp_pkg::TRP_USR_IDLE:
      begin
        if (go)
        begin
          st_next = trp_pkg::TRP_USR_ISSUE;
        end
      end
      trp_pkg::TRP_USR_ISSUE:
      begin
        if (!port_if.reconfig_busy)
        begin
          st_next = trp_pkg::TRP_USR_WAIT;
        end
      end
      trp_pkg::TRP_USR_WAIT:
      begin
        if (port_if.reconfig_ready)
        begin
          if (!ctrl_reg[`TRP_CTRL_WE_BIT])
          begin
            rdata_next = port_if.reconfig_read_data;
          end
          done_next = 1'b1;
          st_next = trp_pkg::TRP_USR_IDLE;
        end
      end
      default:
      begin
        st_next = trp_pkg::TRP_USR_IDLE;
      end
    endcase
  end

  // enable is high for exactly one cycle: the issue cycle in which busy is low
  assign port_if.reconfig_access_enable = (st_reg == trp_pkg::TRP_USR_ISSUE)
    && !port_if.reconfig_busy;
  assign port_if.reconfig_address = ctrl_reg[`TRP_ADDR_W-1:0];
  assign port_if.reconfig_write_enable = ctrl_reg[`TRP_CTRL_WE_BIT];
  assign port_if.reconfig_write_data = wdata_reg[`TRP_DATA_W-1:0];

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg <= trp_pkg::TRP_USR_IDLE;
      ctrl_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      done_reg <= 1'b0;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= '0;
      wd_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdat_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      ctrl_reg <= ctrl_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      awaddr_reg <= awaddr_next;
      wd_reg <= wd_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdat_reg <= rdat_next;
    end
  end
endmodule // trp_user
`default_nettype wire

// *** core/trp_defs.svh ***
`ifndef TRP_DEFS_SVH
`define TRP_DEFS_SVH
`define TRP_ADDR_W 9
`define TRP_DATA_W 16
`define TRP_TXBUF_W 2
`define TRP_LATENCY 3
`define TRP_MEM_DEPTH 512
`define TRP_RD_DEFAULT 16'h0000
`define TRP_TXBUF_DEFAULT 2'h0
`define TRP_REG_CTRL 32'h0000_0000
`define TRP_REG_WDATA 32'h0000_0004
`define TRP_REG_STATUS 32'h0000_0008
`define TRP_REG_RDATA 32'h0000_000c
`define TRP_CTRL_GO_BIT 31
`define TRP_CTRL_WE_BIT 16
`define TRP_STAT_BUSY_BIT 0
`define TRP_STAT_DONE_BIT 1
`define TRP_STAT_RXPMA_BIT 2
`define TRP_STAT_TXBUF_LSB 4
`define TRP_RESP_OKAY 2'h0
`define TRP_RESP_SLVERR 2'h2
`endif

// *** core/trp_pkg.sv ***
package trp_pkg;
  typedef enum logic [1:0] {
    TRP_DEV_IDLE = 2'b00,
    TRP_DEV_WAIT = 2'b01,
    TRP_DEV_DONE = 2'b10
  } trp_dev_state_t;
  typedef enum logic [1:0] {
    TRP_USR_IDLE = 2'b00,
    TRP_USR_ISSUE = 2'b01,
    TRP_USR_WAIT = 2'b10
  } trp_usr_state_t;
endpackage

// *** core/trp_if.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "trp_defs.svh"
interface trp_if;
  logic [`TRP_ADDR_W-1:0] reconfig_address;
  logic reconfig_access_enable;
  logic reconfig_write_enable;
  logic [`TRP_DATA_W-1:0] reconfig_write_data;
  logic [`TRP_DATA_W-1:0] reconfig_read_data;
  logic reconfig_ready;
  logic reconfig_busy;
  logic rx_medium_attach_reset_done;
  logic [`TRP_TXBUF_W-1:0] tx_buffer_condition;
  modport device (
    input reconfig_address, reconfig_access_enable, reconfig_write_enable,
    input reconfig_write_data,
    output reconfig_read_data, reconfig_ready, reconfig_busy,
    output rx_medium_attach_reset_done, tx_buffer_condition
  );
  modport user (
    output reconfig_address, reconfig_access_enable, reconfig_write_enable,
    output reconfig_write_data,
    input reconfig_read_data, reconfig_ready, reconfig_busy,
    input rx_medium_attach_reset_done, tx_buffer_condition
  );
endinterface
`default_nettype wire

// *** core/trp_device.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "trp_defs.svh"
module trp_device #(
  parameter bit PORTS_ENABLED = 1'b1,
  parameter bit HAS_RXPMA_DONE = 1'b0,
  parameter int LATENCY = `TRP_LATENCY
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic rx_pma_done_in,
  input wire logic [`TRP_TXBUF_W-1:0] tx_buf_status_in,
  trp_if.device port_if
);
  localparam int DEPTH = `TRP_MEM_DEPTH;
  localparam int CW = $clog2(LATENCY + 1);

  trp_pkg::trp_dev_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [`TRP_ADDR_W-1:0] addr_reg, addr_next;
  logic we_reg, we_next;
  logic [`TRP_DATA_W-1:0] wd_reg, wd_next;
  logic [`TRP_DATA_W-1:0] rd_reg, rd_next;
  logic [`TRP_DATA_W-1:0] mem [DEPTH];
  logic [`TRP_TXBUF_W-1:0] txbuf_reg, txbuf_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    we_next = we_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    txbuf_next = PORTS_ENABLED ? tx_buf_status_in : `TRP_TXBUF_DEFAULT;
    unique case (state_reg)
      trp_pkg::TRP_DEV_IDLE:
      begin
        if (PORTS_ENABLED && port_if.reconfig_access_enable)
        begin
          addr_next = port_if.reconfig_address;
          we_next = port_if.reconfig_write_enable;
          wd_next = port_if.reconfig_write_data;
          cnt_next = CW'(LATENCY - 1);
          state_next = trp_pkg::TRP_DEV_WAIT;
        end
      end
      trp_pkg::TRP_DEV_WAIT:
      begin
        if (cnt_reg == '0)
        begin
          if (!we_reg)
          begin
            rd_next = mem[addr_reg];
          end
          state_next = trp_pkg::TRP_DEV_DONE;
        end
        else
        begin
          cnt_next = cnt_reg - CW'(1);
        end
      end
      trp_pkg::TRP_DEV_DONE:
      begin
        state_next = trp_pkg::TRP_DEV_IDLE;
      end
      default:
      begin
        state_next = trp_pkg::TRP_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= trp_pkg::TRP_DEV_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      we_reg <= 1'b0;
      wd_reg <= '0;
      rd_reg <= `TRP_RD_DEFAULT;
      txbuf_reg <= `TRP_TXBUF_DEFAULT;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      we_reg <= we_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      txbuf_reg <= txbuf_next;
    end
  end

  // configuration store; no reset so it maps to block memory
  always_ff @(posedge clk_in)
  begin
    if (state_reg == trp_pkg::TRP_DEV_WAIT && cnt_reg == '0 && we_reg)
    begin
      mem[addr_reg] <= wd_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // disabled option: all outputs except rx_medium_attach_reset_done stay at defaults
  assign port_if.reconfig_ready = PORTS_ENABLED && (state_reg == trp_pkg::TRP_DEV_DONE);
  assign port_if.reconfig_busy = PORTS_ENABLED && (state_reg != trp_pkg::TRP_DEV_IDLE);
  assign port_if.reconfig_read_data = PORTS_ENABLED ? rd_reg : `TRP_RD_DEFAULT;
  assign port_if.rx_medium_attach_reset_done = HAS_RXPMA_DONE ? rx_pma_done_in : 1'b1;
  assign port_if.tx_buffer_condition = txbuf_reg;
endmodule // trp_device
`default_nettype wire

// *** tb/trp_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "trp_defs.svh"
module trp_chk #(
  parameter int LATENCY = `TRP_LATENCY
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [`TRP_ADDR_W-1:0] reconfig_address,
  input wire logic reconfig_access_enable,
  input wire logic reconfig_write_enable,
  input wire logic [`TRP_DATA_W-1:0] reconfig_write_data,
  input wire logic [`TRP_DATA_W-1:0] reconfig_read_data,
  input wire logic reconfig_ready,
  input wire logic reconfig_busy,
  input wire logic rx_medium_attach_reset_done,
  input wire logic [`TRP_TXBUF_W-1:0] tx_buffer_condition
);
  localparam int RDY_DLY = LATENCY + 1;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////
  a_ready_latency: assert property (
    reconfig_access_enable && !reconfig_busy |-> ##RDY_DLY reconfig_ready)
    else $error("ready late or missing");
  a_busy_window: assert property (
    reconfig_access_enable && !reconfig_busy |=> reconfig_busy [*4] ##1 !reconfig_busy)
    else $error("busy window wrong");
  a_ready_single: assert property (reconfig_ready |=> !reconfig_ready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (
    reconfig_ready |-> $past(reconfig_access_enable, RDY_DLY))
    else $error("ready without access");
  a_read_hold: assert property ($changed(reconfig_read_data) |-> reconfig_ready)
    else $error("read data moved outside ready");
  a_enable_pulse: assert property (reconfig_access_enable |=> !reconfig_access_enable)
    else $error("enable held too long");
  a_enable_idle: assert property (reconfig_access_enable |-> !reconfig_busy)
    else $error("access issued while busy");
  a_reset_done: assert property (rx_medium_attach_reset_done)
    else $error("reset done not high");
  c_write: cover property (reconfig_access_enable && reconfig_write_enable);
  c_read: cover property (reconfig_access_enable && !reconfig_write_enable);
  c_ready: cover property (reconfig_ready && tx_buffer_condition == 2'h3);
endmodule // trp_chk
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "trp_defs.svh"
module testbench;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pma_done = 1'b0;
  logic [1:0] bresp, rresp, txbuf = '0;
  int num_errors = 0;
  int total_checks = 0;
  trp_if link();
  // second device with the option off, driven straight from the bench
  trp_if link_off();
  trp_device #(.PORTS_ENABLED(1'b0)) trp_device_off_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .rx_pma_done_in(pma_done), .tx_buf_status_in(txbuf), .port_if(link_off));
  trp_device trp_device_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .rx_pma_done_in(pma_done),
    .tx_buf_status_in(txbuf), .port_if(link));
  trp_user trp_user_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_if(link));
  trp_chk trp_chk_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .reconfig_address(link.reconfig_address),
    .reconfig_access_enable(link.reconfig_access_enable),
    .reconfig_write_enable(link.reconfig_write_enable),
    .reconfig_write_data(link.reconfig_write_data),
    .reconfig_read_data(link.reconfig_read_data), .reconfig_ready(link.reconfig_ready),
    .reconfig_busy(link.reconfig_busy),
    .rx_medium_attach_reset_done(link.rx_medium_attach_reset_done),
    .tx_buffer_condition(link.tx_buffer_condition));
  always #25 clk_in = ~clk_in;
  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 50)
    begin
      num_errors++;
      test_done();
    end
  endtask
  ////////////////////////////////////////
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    hang(n);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    hang(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one link access through the control register, then poll done
  task automatic launch(input logic [8:0] adr, input logic we, input logic [15:0] d);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    axi_wr(`TRP_REG_WDATA, {16'h0000, d}, r);
    axi_wr(`TRP_REG_CTRL, {1'b1, 14'h0000, we, 7'h00, adr}, r);
    n = 0;
    do
    begin
      axi_rd(`TRP_REG_STATUS, s, r);
      n++;
    end while (s[`TRP_STAT_DONE_BIT] !== 1'b1 && n < 50);
    hang(n);
    check("busy after done", {31'h0, s[`TRP_STAT_BUSY_BIT]}, 32'h0);
  endtask
  ////////////////////////////////////////
  task automatic t_access();
    logic [8:0] adr [3] = '{9'h000, 9'h1ff, 9'h0a5};
    logic [15:0] dat [3] = '{16'hffff, 16'h0001, 16'h5a3c};
    logic [31:0] v;
    logic [1:0] r;
    foreach (adr[i])
      launch(adr[i], 1'b1, dat[i]);
    foreach (adr[i])
    begin
      launch(adr[i], 1'b0, 16'h0000);
      axi_rd(`TRP_REG_RDATA, v, r);
      check("read back", v, {16'h0000, dat[i]});
    end
    // a write must leave the last read value in place
    launch(9'h000, 1'b1, 16'h1234);
    axi_rd(`TRP_REG_RDATA, v, r);
    check("read held", v, {16'h0000, dat[2]});
    launch(9'h000, 1'b0, 16'h0000);
    axi_rd(`TRP_REG_RDATA, v, r);
    check("rewrite", v, 32'h0000_1234);
    $display("test access done");
  endtask
  task automatic t_status();
    logic [31:0] s;
    logic [1:0] r;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in);
      txbuf <= i[1:0];
      pma_done <= i[0];
      axi_rd(`TRP_REG_STATUS, s, r);
      check("tx buffer", {30'h0, s[5:4]}, i);
      check("rx reset done", {31'h0, s[`TRP_STAT_RXPMA_BIT]}, 32'h1);
    end
    // access with buffer status 2'h3, so the ready cover is reached
    launch(9'h000, 1'b0, 16'h0000);
    $display("test status done");
  endtask
  task automatic t_off();
    @(posedge clk_in);
    link_off.reconfig_address <= 9'h000;
    link_off.reconfig_write_enable <= 1'b0;
    link_off.reconfig_write_data <= 16'hffff;
    link_off.reconfig_access_enable <= 1'b1;
    repeat (6)
    begin
      @(posedge clk_in);
      check("off ready", {31'h0, link_off.reconfig_ready}, 32'h0);
      check("off busy", {31'h0, link_off.reconfig_busy}, 32'h0);
      check("off read data", {16'h0000, link_off.reconfig_read_data}, 32'h0);
      check("off tx buffer", {30'h0, link_off.tx_buffer_condition}, 32'h0);
    end
    link_off.reconfig_access_enable <= 1'b0;
    $display("test disabled option done");
  endtask
  task automatic t_bad();
    logic [31:0] v;
    logic [1:0] r;
    axi_wr(32'h0000_0010, 32'hffff_ffff, r);
    check("unmapped write", {30'h0, r}, `TRP_RESP_SLVERR);
    axi_rd(32'h0000_0014, v, r);
    check("unmapped read", {30'h0, r}, `TRP_RESP_SLVERR);
    axi_wr(`TRP_REG_RDATA, 32'h0000_beef, r);
    check("ro write resp", {30'h0, r}, `TRP_RESP_OKAY);
    axi_rd(`TRP_REG_RDATA, v, r);
    check("ro unchanged", v, 32'h0000_1234);
    $display("test bad access done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_access();
    t_status();
    t_off();
    t_bad();
    test_done();
  end
endmodule // testbench
`default_nettype wire
